//--- rtl/qdac_host.sv
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
// Function
// - Wait setup after write rise before strobe
// - Mode low control, high data; select channel
// - Write 020 for parallel twos normal
// - Write 011 for half-supply bias, main
module qdac_host (
    input  wire logic                           sys_clk,
    input  wire logic                           nrst,
    input  wire logic [qdac_pkg::ADDR_W-1:0]    s_awaddr,
    input  wire logic                           s_awvalid,
    output logic                                s_awready,
    input  wire logic [qdac_pkg::DATA_W-1:0]    s_wdata,
    input  wire logic [3:0]                     s_wstrb,
    input  wire logic                           s_wvalid,
    output logic                                s_wready,
    output logic [1:0]                          s_bresp,
    output logic                                s_bvalid,
    input  wire logic                           s_bready,
    input  wire logic [qdac_pkg::ADDR_W-1:0]    s_araddr,
    input  wire logic                           s_arvalid,
    output logic                                s_arready,
    output logic [qdac_pkg::DATA_W-1:0]         s_rdata,
    output logic [1:0]                          s_rresp,
    output logic                                s_rvalid,
    input  wire logic                           s_rready,
    output logic [qdac_pkg::BUS_W-1:0]          dac_data,
    output logic [qdac_pkg::SEL_W-1:0]          channel_select,
    output logic                                dac_mode,
    output logic                                dac_write_n,
    output logic                                dac_update_strobe_n
);
    import qdac_pkg::*;
    qdac_state_t          state;
    qdac_state_t          next_state;
    logic [CNT_W-1:0]     cnt;
    logic [CNT_W-1:0]     next_cnt;
    logic [BUS_W-1:0]     next_dac_data;
    logic [SEL_W-1:0]     next_channel_select;
    logic                 next_dac_mode;
    logic                 next_dac_write_n;
    logic                 next_dac_update_strobe_n;
    logic                 pend;
    logic                 next_pend;
    logic [15:0]          wrcnt;
    logic [15:0]          next_wrcnt;
    logic                 wr_pulse;
    logic [ADDR_W-1:0]    wr_addr;
    logic [DATA_W-1:0]    wr_data;
    logic                 wr_ok;
    logic [ADDR_W-1:0]    rd_addr;
    logic [DATA_W-1:0]    rd_data;
    logic                 rd_ok;
    logic [DATA_W-1:0]    cmd;
    logic [DATA_W-1:0]    ctrl;
    logic                 cmd_load;
    logic                 ctrl_load;
    logic                 busy;
    logic                 sync_mode;
    logic                 upd_req;

    qdac_axil_slave u_bus (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_pulse  (wr_pulse),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_ok     (wr_ok),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_ok     (rd_ok)
    );

    // Command write accepted only while idle
    assign busy      = (state != QD_IDLE);
    assign cmd_load  = wr_pulse && (wr_addr == REG_CMD) && !busy;
    assign ctrl_load = wr_pulse && (wr_addr == REG_CTRL);
    assign wr_ok     = ((wr_addr == REG_CMD) && !busy) || (wr_addr == REG_CTRL);

    qdac_cmd_reg #(.WIDTH(DATA_W)) u_cmd (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .load    (cmd_load),
        .din     (wr_data),
        .dout    (cmd)
    );

    qdac_cmd_reg #(.WIDTH(DATA_W)) u_ctrl (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .load    (ctrl_load),
        .din     (wr_data),
        .dout    (ctrl)
    );

    assign sync_mode = ctrl[CTRL_SYNC_BIT];

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = '0;
        case (rd_addr)
            REG_CMD:    rd_data = cmd;
            REG_CTRL:   rd_data = ctrl;
            REG_STATUS: begin
                rd_data[STAT_BUSY_BIT] = busy;
                rd_data[STAT_PEND_BIT] = pend;
                rd_data[STAT_SYNC_BIT] = sync_mode;
            end
            REG_WRCNT:  rd_data = {16'h0000, wrcnt};
            default:    rd_ok = 1'b0;
        endcase
    end

    // Standalone update pulse from the control register
    assign upd_req = ctrl_load && wr_data[CTRL_PULSE_BIT];

    always_comb begin
        next_state               = state;
        next_cnt                 = cnt;
        next_dac_data            = dac_data;
        next_channel_select      = channel_select;
        next_dac_mode            = dac_mode;
        next_dac_write_n         = dac_write_n;
        next_dac_update_strobe_n = dac_update_strobe_n;
        next_pend                = pend;
        next_wrcnt               = wrcnt;
        case (state)
            QD_IDLE: begin
                // Hold strobe low in synchronous mode, except while a CTRL_PULSE_BIT update pulse runs
                next_dac_update_strobe_n = ~sync_mode;
                if (cmd_load) begin
                    // Mode low control, high data; select drives channel
                    next_dac_data       = wr_data[CMD_DATA_LSB +: BUS_W];
                    next_channel_select = wr_data[CMD_SEL_LSB +: SEL_W];
                    next_dac_mode       = wr_data[CMD_MODE_BIT];
                    next_cnt            = CNT_W'(SETUP_CYC);
                    next_state          = QD_SETUP;
                end else if (upd_req) begin
                    next_dac_update_strobe_n = 1'b1;
                    next_cnt   = CNT_W'(UPD_SETUP_CYC);
                    next_state = QD_USETUP;
                end
            end
            QD_SETUP: begin
                if (cnt <= 1) begin
                    next_dac_write_n = 1'b0;
                    next_cnt         = CNT_W'(STROBE_CYC);
                    next_state       = QD_STROBE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            QD_STROBE: begin
                if (cnt <= 1) begin
                    // Device latches bus on this rising write edge
                    next_dac_write_n = 1'b1;
                    next_wrcnt       = wrcnt + 1'b1;
                    next_cnt         = CNT_W'(UPD_SETUP_CYC);
                    next_state       = QD_HOLD;
                    if (dac_mode == MODE_DATA && !sync_mode) begin
                        next_pend = 1'b1;
                    end
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            QD_HOLD: begin
                if (cnt <= 1) begin
                    if (!sync_mode && cmd[CMD_UPD_BIT]) begin
                        next_cnt   = CNT_W'(UPD_PULSE_CYC);
                        next_dac_update_strobe_n = 1'b0;
                        next_state = QD_UPULSE;
                    end else begin
                        next_state = QD_IDLE;
                    end
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            QD_USETUP: begin
                if (cnt <= 1) begin
                    next_cnt                 = CNT_W'(UPD_PULSE_CYC);
                    next_dac_update_strobe_n = 1'b0;
                    next_state               = QD_UPULSE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            QD_UPULSE: begin
                if (cnt <= 1) begin
                    next_dac_update_strobe_n = 1'b1;
                    next_pend                = 1'b0;
                    next_state               = QD_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: next_state = QD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state               <= QD_IDLE;
            cnt                 <= '0;
            dac_data            <= '0;
            channel_select      <= '0;
            dac_mode            <= MODE_CONTROL;
            dac_write_n         <= 1'b1;
            dac_update_strobe_n <= 1'b1;
            pend                <= 1'b0;
            wrcnt               <= '0;
        end else begin
            state               <= next_state;
            cnt                 <= next_cnt;
            dac_data            <= next_dac_data;
            channel_select      <= next_channel_select;
            dac_mode            <= next_dac_mode;
            dac_write_n         <= next_dac_write_n;
            dac_update_strobe_n <= next_dac_update_strobe_n;
            pend                <= next_pend;
            wrcnt               <= next_wrcnt;
        end
    end
endmodule

//--- include/qdac_pkg.sv
package qdac_pkg;
    localparam int DATA_W      = 32;
    localparam int ADDR_W      = 6;
    localparam int BUS_W       = 10;
    localparam int SEL_W       = 3;
    localparam int MAIN_W      = 10;
    localparam int SUB_W       = 8;
    localparam int NCHAN       = 4;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CMD    = 6'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 6'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h08;
    localparam logic [ADDR_W-1:0] REG_WRCNT  = 6'h0C;
    // Command word fields
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_SEL_LSB  = 16;
    localparam int CMD_MODE_BIT = 20;
    localparam int CMD_UPD_BIT  = 21;
    // Control word fields
    localparam int CTRL_SYNC_BIT  = 0;
    localparam int CTRL_PULSE_BIT = 1;
    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PEND_BIT = 1;
    localparam int STAT_SYNC_BIT = 2;
    // Mode pin levels
    localparam logic MODE_CONTROL = 1'b0;
    localparam logic MODE_DATA    = 1'b1;
    // Host-side codes
    localparam logic [BUS_W-1:0] SYSCTL_PAR10_TWOS = 10'h020;
    localparam logic [BUS_W-1:0] CHCTL_VDD2_MAIN   = 10'h011;
    localparam logic [BUS_W-1:0] TWOS_MAIN_LOW     = 10'h200;
    localparam logic [BUS_W-1:0] TWOS_MAIN_HIGH    = 10'h1FF;
    localparam logic [BUS_W-1:0] OB_MAIN_MID       = 10'h200;
    localparam logic [SUB_W-1:0] OB_SUB_ZERO       = 8'h80;
    // Timing
    localparam int CLK_NS       = 10;
    localparam int SETUP_NS     = 20;
    localparam int STROBE_NS    = 20;
    localparam int UPD_SETUP_NS = 20;
    localparam int UPD_PULSE_NS = 20;
    localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int UPD_SETUP_CYC = (UPD_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int UPD_PULSE_CYC = (UPD_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        QD_IDLE, QD_SETUP, QD_STROBE, QD_HOLD, QD_USETUP, QD_UPULSE
    } qdac_state_t;
endpackage

//--- rtl/qdac_axil_slave.sv
`timescale 1ns/10ps
module qdac_axil_slave (
    input  wire logic                           sys_clk,
    input  wire logic                           nrst,
    input  wire logic [qdac_pkg::ADDR_W-1:0]    s_awaddr,
    input  wire logic                           s_awvalid,
    output logic                                s_awready,
    input  wire logic [qdac_pkg::DATA_W-1:0]    s_wdata,
    input  wire logic [3:0]                     s_wstrb,
    input  wire logic                           s_wvalid,
    output logic                                s_wready,
    output logic [1:0]                          s_bresp,
    output logic                                s_bvalid,
    input  wire logic                           s_bready,
    input  wire logic [qdac_pkg::ADDR_W-1:0]    s_araddr,
    input  wire logic                           s_arvalid,
    output logic                                s_arready,
    output logic [qdac_pkg::DATA_W-1:0]         s_rdata,
    output logic [1:0]                          s_rresp,
    output logic                                s_rvalid,
    input  wire logic                           s_rready,
    output logic                                wr_pulse,
    output logic [qdac_pkg::ADDR_W-1:0]         wr_addr,
    output logic [qdac_pkg::DATA_W-1:0]         wr_data,
    input  wire logic                           wr_ok,
    output logic [qdac_pkg::ADDR_W-1:0]         rd_addr,
    input  wire logic [qdac_pkg::DATA_W-1:0]    rd_data,
    input  wire logic                           rd_ok
);
    import qdac_pkg::*;
    logic                 have_aw;
    logic                 have_w;
    logic                 next_have_aw;
    logic                 next_have_w;
    logic [ADDR_W-1:0]    next_wr_addr;
    logic [DATA_W-1:0]    next_wr_data;
    logic                 next_wr_pulse;
    logic                 next_bvalid;
    logic [1:0]           next_bresp;
    logic                 next_rvalid;
    logic [1:0]           next_rresp;
    logic [DATA_W-1:0]    next_rdata;
    logic                 next_awready;
    logic                 next_wready;
    logic                 next_arready;

    assign rd_addr   = s_araddr;

    always_comb begin
        next_have_aw  = have_aw;
        next_have_w   = have_w;
        next_wr_addr  = wr_addr;
        next_wr_data  = wr_data;
        next_wr_pulse = 1'b0;
        next_bvalid   = s_bvalid;
        next_bresp    = s_bresp;
        if (s_awvalid && s_awready) begin
            next_have_aw = 1'b1;
            next_wr_addr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            next_have_w  = 1'b1;
            next_wr_data = s_wdata;
        end
        if (have_aw && have_w) begin
            next_have_aw  = 1'b0;
            next_have_w   = 1'b0;
            next_wr_pulse = 1'b1;
        end
        if (wr_pulse) begin
            next_bvalid = 1'b1;
            next_bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_bvalid && s_bready) begin
            next_bvalid = 1'b0;
        end
        // Ready flops track next holding state
        next_awready = ~next_have_aw & ~next_bvalid;
        next_wready  = ~next_have_w & ~next_bvalid;
    end

    always_comb begin
        next_rvalid = s_rvalid;
        next_rresp  = s_rresp;
        next_rdata  = s_rdata;
        if (s_arvalid && s_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_ok ? rd_data : '0;
            next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_rvalid && s_rready) begin
            next_rvalid = 1'b0;
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            have_aw  <= 1'b0;
            have_w   <= 1'b0;
            wr_addr  <= '0;
            wr_data  <= '0;
            wr_pulse <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OKAY;
            s_rvalid <= 1'b0;
            s_rresp  <= RESP_OKAY;
            s_rdata  <= '0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_arready <= 1'b1;
        end else begin
            have_aw  <= next_have_aw;
            have_w   <= next_have_w;
            wr_addr  <= next_wr_addr;
            wr_data  <= next_wr_data;
            wr_pulse <= next_wr_pulse;
            s_bvalid <= next_bvalid;
            s_bresp  <= next_bresp;
            s_rvalid <= next_rvalid;
            s_rresp  <= next_rresp;
            s_rdata  <= next_rdata;
            s_awready <= next_awready;
            s_wready  <= next_wready;
            s_arready <= next_arready;
        end
    end
endmodule

//--- rtl/qdac_cmd_reg.sv
`timescale 1ns/10ps
module qdac_cmd_reg #(
    parameter int WIDTH = 32
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              load,
    input  wire logic [WIDTH-1:0]  din,
    output logic [WIDTH-1:0]       dout
);
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_dout = load ? din : dout;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout <= '0;
        end else begin
            dout <= next_dout;
        end
    end
endmodule

//--- verification/qdac_host_monitor.sv
`timescale 1ns/10ps
module qdac_host_monitor (
    input wire logic                        sys_clk,
    input wire logic                        nrst,
    input wire logic                        s_awvalid,
    input wire logic                        s_awready,
    input wire logic                        s_wvalid,
    input wire logic                        s_wready,
    input wire logic [1:0]                  s_bresp,
    input wire logic                        s_bvalid,
    input wire logic                        s_bready,
    input wire logic                        s_arvalid,
    input wire logic                        s_arready,
    input wire logic [qdac_pkg::DATA_W-1:0] s_rdata,
    input wire logic                        s_rvalid,
    input wire logic                        s_rready,
    input wire logic [qdac_pkg::BUS_W-1:0]  dac_data,
    input wire logic [qdac_pkg::SEL_W-1:0]  channel_select,
    input wire logic                        dac_mode,
    input wire logic                        dac_write_n,
    input wire logic                        dac_update_strobe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_bvalid_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    a_rvalid_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read response dropped early");
    a_write_resp_lat: assert property (s_awvalid && s_awready && s_wvalid && s_wready
        |-> ##3 s_bvalid)
        else $error("write response late");
    a_read_resp_lat: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read response late");
    a_strobe_width: assert property ($fell(dac_write_n) |-> ##1 !dac_write_n ##1 dac_write_n)
        else $error("write strobe width wrong");
    a_pins_steady: assert property (!dac_write_n |-> $stable(dac_data) &&
        $stable(channel_select) && $stable(dac_mode))
        else $error("bus moved during write strobe");
    a_update_setup: assert property ($fell(dac_update_strobe_n) |-> dac_write_n &&
        $past(dac_write_n) && $past(dac_write_n, 2))
        else $error("update strobe too soon after write");
    a_update_width: assert property ($rose(dac_update_strobe_n) |->
        !$past(dac_update_strobe_n) && !$past(dac_update_strobe_n, 2))
        else $error("update pulse too short");
endmodule
bind qdac_host qdac_host_monitor qdac_host_monitor_inst (.*);

//--- verification/qdac_dev_model.sv
`timescale 1ns/10ps
module qdac_dev_model #(
    parameter int CH_BIT   = 4,
    parameter int SUB_BIT  = 2,
    parameter int TWOS_BIT = 5
) (
    input wire logic [qdac_pkg::BUS_W-1:0] dac_data,
    input wire logic [qdac_pkg::SEL_W-1:0] channel_select,
    input wire logic                       dac_mode,
    input wire logic                       dac_write_n,
    input wire logic                       dac_update_strobe_n
);
    import qdac_pkg::*;
    // Control word bit positions are arbitrary
    logic [MAIN_W-1:0] main_dr  [NCHAN];
    logic [SUB_W-1:0]  sub_dr   [NCHAN];
    logic [MAIN_W-1:0] main_out [NCHAN];
    logic [SUB_W-1:0]  sub_out  [NCHAN];
    logic              sub_sel  [NCHAN];
    logic              twos = 1'b0;
    int                viol = 0;
    realtime           t_rise = 0;
    initial begin
        for (int i = 0; i < NCHAN; i++) begin
            main_dr[i] = '0;
            sub_dr[i] = '0;
            main_out[i] = '0;
            sub_out[i] = '0;
            sub_sel[i] = 1'b0;
        end
    end
    task automatic load_all();
        for (int i = 0; i < NCHAN; i++) begin
            main_out[i] = main_dr[i] ^ {twos, 9'h000};
            sub_out[i] = sub_dr[i] ^ {twos, 7'h00};
        end
    endtask
    always @(posedge dac_write_n) if ($realtime > CLK_NS) begin
        t_rise = $realtime;
        if (dac_mode == MODE_DATA) begin
            if (sub_sel[channel_select[1:0]]) sub_dr[channel_select[1:0]] = dac_data[7:0];
            else main_dr[channel_select[1:0]] = dac_data;
        end else if (dac_data[CH_BIT]) sub_sel[channel_select[1:0]] = dac_data[SUB_BIT];
        else twos = dac_data[TWOS_BIT];
        if (!dac_update_strobe_n) load_all();
    end
    always @(negedge dac_update_strobe_n) if ($realtime > 0) begin
        if ($realtime - t_rise < UPD_SETUP_NS) viol++;
        load_all();
    end
endmodule

//--- verification/test_qdac_host.sv
`timescale 1ns/10ps
module test_qdac_host;
    import qdac_pkg::*;
    logic              sys_clk = 1'b0, nrst = 1'b0;
    logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
    logic [DATA_W-1:0] s_wdata = '0, s_rdata;
    logic [3:0]        s_wstrb = 4'hF;
    logic              s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic              s_arvalid = 1'b0, s_rready = 1'b0;
    logic              s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]        s_bresp, s_rresp, rsp;
    logic [BUS_W-1:0]  dac_data;
    logic [SEL_W-1:0]  channel_select;
    logic              dac_mode, dac_write_n, dac_update_strobe_n;
    int                err_count = 0, compares = 0, wr_total = 0;
    logic [31:0]       lfsr = 32'h6F001006, rd;
    logic [9:0]        rm [NCHAN], ro_m [NCHAN];
    logic [7:0]        rs [NCHAN], ro_s [NCHAN];
    logic              rsel [NCHAN];
    logic              rtwos = 1'b0, rsync = 1'b0, pend = 1'b0;
    qdac_host qdac_host_inst (.*);
    qdac_dev_model qdac_dev_model_inst (.*);
    always #5 sys_clk = ~sys_clk;
    function logic [9:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[9:0];
    endfunction
    task automatic stop_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw = 0, w = 0;
        @(posedge sys_clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (int n = 0; n < 60; n++) begin
            @(posedge sys_clk);
            if (!aw && s_awready) begin
                aw = 1;
                s_awvalid <= 1'b0;
            end
            if (!w && s_wready) begin
                w = 1;
                s_wvalid <= 1'b0;
            end
            if (s_bvalid) begin
                r = s_bresp;
                s_bready <= 1'b0;
                return;
            end
        end
        err_count++;
        stop_test();
    endtask
    task automatic axi_rd(input logic [5:0] a);
        bit ar = 0;
        @(posedge sys_clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (int n = 0; n < 60; n++) begin
            @(posedge sys_clk);
            if (!ar && s_arready) begin
                ar = 1;
                s_arvalid <= 1'b0;
            end
            if (s_rvalid) begin
                rd = s_rdata;
                rsp = s_rresp;
                s_rready <= 1'b0;
                return;
            end
        end
        err_count++;
        stop_test();
    endtask
    task automatic wr_ok(input logic [5:0] a, input logic [31:0] d);
        axi_wr(a, d, rsp);
        cmp(rsp, RESP_OKAY);
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 40; n++) begin
            axi_rd(REG_STATUS);
            if (rd[STAT_BUSY_BIT] === 1'b0) return;
        end
        err_count++;
        stop_test();
    endtask
    task automatic ref_upd();
        for (int i = 0; i < NCHAN; i++) begin
            ro_m[i] = rm[i] ^ {rtwos, 9'h000};
            ro_s[i] = rs[i] ^ {rtwos, 7'h00};
        end
        pend = 1'b0;
    endtask
    task automatic chk();
        for (int i = 0; i < NCHAN; i++) begin
            cmp(qdac_dev_model_inst.main_out[i], ro_m[i]);
            cmp(qdac_dev_model_inst.sub_out[i], ro_s[i]);
        end
        axi_rd(REG_STATUS);
        cmp(rd, {29'h0, rsync, pend, 1'b0});
        axi_rd(REG_WRCNT);
        cmp(rd, wr_total);
    endtask
    task automatic cmd(input logic m, input int ch, input logic [9:0] d, input logic u,
        input bit busy_try);
        logic [31:0] w = '0;
        w[9:0] = d;
        w[CMD_SEL_LSB +: SEL_W] = SEL_W'(ch);
        w[CMD_MODE_BIT] = m;
        w[CMD_UPD_BIT] = u;
        wr_ok(REG_CMD, w);
        if (busy_try) begin
            axi_wr(REG_CMD, w ^ 32'h3FF, rsp);
            cmp(rsp, RESP_SLVERR);
        end
        wait_idle();
        wr_total++;
        if (m) begin
            if (rsel[ch]) rs[ch] = d[7:0];
            else rm[ch] = d;
            pend = !rsync;
        end else if (d[4]) rsel[ch] = d[2];
        else rtwos = d[5];
        if (rsync || u) ref_upd();
        chk();
    endtask
    initial begin
        for (int i = 0; i < NCHAN; i++) begin
            rm[i] = '0;
            rs[i] = '0;
            rsel[i] = 1'b0;
        end
        ref_upd();
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        cmp(dac_write_n, 1'b1);
        cmp(dac_update_strobe_n, 1'b1);
        chk();
        axi_rd(6'h10);
        cmp(rsp, RESP_SLVERR);
        cmp(rd, 32'h0);
        axi_wr(6'h10, 32'h1, rsp);
        cmp(rsp, RESP_SLVERR);
        axi_wr(REG_STATUS, 32'h1, rsp);
        cmp(rsp, RESP_SLVERR);
        $display("test reset done");
        cmd(1, 0, rnd(), 1, 0);
        cmd(1, 1, OB_MAIN_MID, 1, 0);
        $display("test offset binary done");
        cmd(0, 2, SYSCTL_PAR10_TWOS, 0, 0);
        for (int c = 0; c < NCHAN; c++) cmd(0, c, CHCTL_VDD2_MAIN, 0, 0);
        for (int c = 0; c < NCHAN; c++) cmd(1, c, rnd(), c == 3, 0);
        $display("test twos update done");
        cmd(0, 1, CHCTL_VDD2_MAIN | 10'h004, 0, 0);
        cmd(1, 1, rnd(), 0, 0);
        cmd(1, 1, {2'b00, OB_SUB_ZERO}, 1, 0);
        cmd(0, 1, CHCTL_VDD2_MAIN, 0, 0);
        cmd(1, 1, rnd(), 1, 1);
        $display("test sub select done");
        for (int k = 0; k < 2; k++) begin
            cmd(0, 0, k ? 10'h000 : SYSCTL_PAR10_TWOS, 0, 0);
            cmd(1, 2, TWOS_MAIN_LOW, 1, 0);
            cmd(1, 2, TWOS_MAIN_HIGH, 1, 0);
            cmd(1, 2, 10'h000, 1, 0);
        end
        $display("test code limits done");
        cmd(1, 3, rnd(), 0, 0);
        wr_ok(REG_CTRL, 32'h2);
        wait_idle();
        ref_upd();
        chk();
        $display("test update pulse done");
        wr_ok(REG_CTRL, 32'h1);
        rsync = 1'b1;
        wait_idle();
        ref_upd();
        cmd(1, 3, rnd(), 0, 0);
        wr_ok(REG_CTRL, 32'h0);
        rsync = 1'b0;
        chk();
        cmp(qdac_dev_model_inst.viol, 0);
        $display("test sync mode done");
        stop_test();
    end
endmodule
